// ==== include/mprt_pkg.sv ====
// Shared constants, encodings and carrier types of the multi-packet request receiver
package mprt_pkg;

  localparam int unsigned MPRT_MAX_TOTAL  = 4128; // Largest assembled request, bytes
  localparam int unsigned MPRT_MAX_SUB    = 90;   // Largest payload of one sub-packet
  localparam int unsigned MPRT_AW         = 13;   // Byte address width of the assembly store
  localparam int unsigned MPRT_SW         = 7;    // Width of a sub-packet size or byte count
  localparam int unsigned MPRT_NSEQ       = 256;  // Sequence numbers are one byte
  localparam logic [7:0]  MPRT_SUM_RESET  = 8'h00;

  typedef enum logic [1:0] {
    MPRT_OP_OPEN  = 2'b00, // open_transfer_channel
    MPRT_OP_DATA  = 2'b01, // send_sub_packet
    MPRT_OP_CLOSE = 2'b10, // close_and_issue_request
    MPRT_OP_ABORT = 2'b11  // abort_transfer
  } mprt_op_t;

  typedef enum logic [1:0] {
    MPRT_RSP_OK   = 2'b00,
    MPRT_RSP_FAIL = 2'b01, // The '?' answer for a bad sub-packet
    MPRT_RSP_ERR  = 2'b10,
    MPRT_RSP_MISS = 2'b11  // Close found a sub-packet not yet confirmed
  } mprt_rsp_t;

  typedef enum logic [2:0] {
    MPRT_ST_IDLE  = 3'b000,
    MPRT_ST_OPEN  = 3'b001,
    MPRT_ST_RECV  = 3'b010,
    MPRT_ST_FIN   = 3'b011,
    MPRT_ST_CHECK = 3'b100,
    MPRT_ST_SEND  = 3'b101
  } mprt_state_t;

  // One decoded command from the host link
  typedef struct packed {
    logic              valid;
    mprt_op_t          op;
    logic [MPRT_AW-1:0] total_length;
    logic [MPRT_SW-1:0] sub_packet_size;
    logic              checksum_enable;
    logic [7:0]        seq;
    logic [7:0]        reply_count;
  } mprt_cmd_t;

  // Payload byte of a sub-packet; last marks the final byte (check byte when enabled)
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } mprt_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } mprt_req_t;

  typedef struct packed {
    logic      valid;
    mprt_rsp_t code;
  } mprt_resp_t;

endpackage

// ==== hw/mprt_sum_acc.sv ====
// Running 8-bit sum of the payload bytes of one sub-packet
`timescale 1ns/100ps
`default_nettype none
module mprt_sum_acc
  import mprt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       add_valid,
  input  wire logic [7:0] add_byte,
  output logic      [7:0] sum
);

  typedef struct packed {
    logic [7:0] sum;
  } mprt_sacc_t;

  mprt_sacc_t sacc_reg;
  mprt_sacc_t sacc_next;

  // Carry out of bit 7 is dropped, the sum keeps only its low byte
  always_comb begin
    sacc_next = sacc_reg;
    if (clear) begin
      sacc_next.sum = MPRT_SUM_RESET;
    end else if (add_valid) begin
      sacc_next.sum = sacc_reg.sum + add_byte;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sacc_reg <= '0;
    end else begin
      sacc_reg <= sacc_next;
    end
  end

  assign sum = sacc_reg.sum;

  a_sum_wrap : assert property (@(posedge core_clk) disable iff (rst)
    add_valid && !clear |=> sum == 8'($past(sum) + $past(add_byte)))
    else $error("sum does not wrap to low byte");

endmodule
`default_nettype wire

// ==== hw/mprt_receiver.sv ====
// Device-side receiver that assembles a multi-packet request and issues it
`timescale 1ns/100ps
`default_nettype none
module mprt_receiver
  import mprt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire mprt_cmd_t   cmd,
  input  wire mprt_byte_t  rx_byte,
  input  wire logic        req_ready,
  output mprt_resp_t       resp,
  output mprt_req_t        req,
  output logic       [7:0] req_reply_count,
  output logic             channel_open
);

  typedef struct packed {
    mprt_state_t          st;
    logic [MPRT_AW-1:0]   total;
    logic [MPRT_SW-1:0]   size;
    logic                 chk_en;
    logic [7:0]           reply;
    logic [MPRT_NSEQ-1:0] confirmed;
    logic [7:0]           seq;
    logic [14:0]          base;
    logic [MPRT_SW-1:0]   cnt;
    logic                 bad;
    logic [7:0]           chk_byte;
    logic [7:0]           idx;
    logic [14:0]          off;
    logic [MPRT_AW-1:0]   ptr;
    logic                 chan_open;
    mprt_req_t            req;
    mprt_resp_t           resp;
  } mprt_rx_t;

  mprt_rx_t s_reg;
  mprt_rx_t s_next;

  logic [7:0]         store [0:MPRT_MAX_TOTAL-1];
  logic               wr_en;
  logic [MPRT_AW-1:0] wr_addr;
  logic               sum_clear;
  logic [7:0]         sum;
  logic [14:0]        remain;
  logic [14:0]        expect_len;

  // Byte offset of a sub-packet from its sequence number
  function automatic logic [14:0] seq_offset(input logic [7:0] sq, input logic [MPRT_SW-1:0] sz);
    seq_offset = 15'(sq * sz);
  endfunction

  mprt_sum_acc mprt_sum_acc_i (
    .core_clk  (core_clk),
    .rst       (rst),
    .clear     (sum_clear),
    .add_valid (wr_en),
    .add_byte  (rx_byte.data),
    .sum       (sum)
  );

  // Last sub-packet may be short; all others must be exactly one full size
  assign remain     = 15'(s_reg.total) - s_reg.base;
  assign expect_len = (remain < 15'(s_reg.size)) ? remain : 15'(s_reg.size);

  // Next-state logic for the whole transfer sequence
  always_comb begin
    s_next           = s_reg;
    s_next.resp      = '0;
    wr_en            = 1'b0;
    wr_addr          = MPRT_AW'(s_reg.base + 15'(s_reg.cnt));
    sum_clear        = 1'b0;
    case (s_reg.st)
      MPRT_ST_IDLE: begin
        if (cmd.valid) begin
          s_next.resp.valid = 1'b1;
          s_next.resp.code  = MPRT_RSP_ERR;
          // One-byte sequence numbers give 256 slots; an open they cannot cover is refused
          if (cmd.op == MPRT_OP_OPEN && cmd.total_length != '0 &&
              cmd.total_length <= MPRT_AW'(MPRT_MAX_TOTAL) && cmd.sub_packet_size != '0 &&
              cmd.sub_packet_size <= MPRT_SW'(MPRT_MAX_SUB) &&
              int'(cmd.total_length) <= int'(cmd.sub_packet_size) * int'(MPRT_NSEQ)) begin
            s_next.st        = MPRT_ST_OPEN;
            s_next.total     = cmd.total_length;
            s_next.size      = cmd.sub_packet_size;
            s_next.chk_en    = cmd.checksum_enable;
            s_next.confirmed = '0;
            s_next.resp.code = MPRT_RSP_OK;
          end
        end
      end
      MPRT_ST_OPEN: begin
        if (cmd.valid) begin
          s_next.resp.valid = 1'b1;
          s_next.resp.code  = MPRT_RSP_ERR;
          if (cmd.op == MPRT_OP_DATA) begin
            // Resends simply overwrite the same slot
            s_next.st   = MPRT_ST_RECV;
            s_next.resp = '0;
            s_next.seq  = cmd.seq;
            s_next.base = seq_offset(cmd.seq, s_reg.size);
            s_next.cnt  = '0;
            s_next.bad  = seq_offset(cmd.seq, s_reg.size) >= 15'(s_reg.total);
            sum_clear   = 1'b1;
          end else if (cmd.op == MPRT_OP_CLOSE) begin
            s_next.st    = MPRT_ST_CHECK;
            s_next.resp  = '0;
            s_next.reply = cmd.reply_count;
            s_next.idx   = '0;
            s_next.off   = '0;
          end
        end
      end
      MPRT_ST_RECV: begin
        if (cmd.valid) begin
          s_next.resp.valid = 1'b1;
          s_next.resp.code  = MPRT_RSP_ERR;
        end
        if (rx_byte.valid) begin
          if (rx_byte.last && s_reg.chk_en) begin
            s_next.chk_byte = rx_byte.data;
            s_next.st       = MPRT_ST_FIN;
          end else begin
            // Bytes past MPRT_MAX_SUB or the total are never stored
            if (s_reg.cnt < MPRT_SW'(MPRT_MAX_SUB) && !s_reg.bad &&
                s_reg.base + 15'(s_reg.cnt) < 15'(s_reg.total)) begin
              wr_en = 1'b1;
            end else begin
              s_next.bad = 1'b1;
            end
            if (s_reg.cnt <= MPRT_SW'(MPRT_MAX_SUB)) begin
              s_next.cnt = s_reg.cnt + 1'b1;
            end
            if (rx_byte.last) begin
              s_next.st = MPRT_ST_FIN;
            end
          end
        end
      end
      MPRT_ST_FIN: begin
        // Sum is complete here, one cycle after the last byte (the check byte when enabled)
        s_next.st         = MPRT_ST_OPEN;
        s_next.resp.valid = 1'b1;
        if (!s_reg.bad && 15'(s_reg.cnt) == expect_len &&
            (!s_reg.chk_en || sum == s_reg.chk_byte)) begin
          s_next.confirmed[s_reg.seq] = 1'b1;
          s_next.resp.code            = MPRT_RSP_OK;
        end else begin
          s_next.confirmed[s_reg.seq] = 1'b0;
          s_next.resp.code            = MPRT_RSP_FAIL;
        end
      end
      MPRT_ST_CHECK: begin
        // Walk the sub-packet slots covering the total length, stopping at the first one not confirmed
        if (s_reg.off >= 15'(s_reg.total)) begin
          s_next.st  = MPRT_ST_SEND;
          s_next.ptr = '0;
        end else if (!s_reg.confirmed[s_reg.idx]) begin
          s_next.st         = MPRT_ST_OPEN;
          s_next.resp.valid = 1'b1;
          s_next.resp.code  = MPRT_RSP_MISS;
        end else begin
          s_next.idx = s_reg.idx + 1'b1;
          s_next.off = s_reg.off + 15'(s_reg.size);
        end
      end
      MPRT_ST_SEND: begin
        if (!s_reg.req.valid || req_ready) begin
          if (s_reg.ptr < s_reg.total) begin
            s_next.req.valid = 1'b1;
            s_next.req.data  = store[s_reg.ptr];
            s_next.req.last  = s_reg.ptr == s_reg.total - 1'b1;
            s_next.ptr       = s_reg.ptr + 1'b1;
          end else begin
            s_next.req        = '0;
            s_next.st         = MPRT_ST_IDLE;
            s_next.resp.valid = 1'b1;
            s_next.resp.code  = MPRT_RSP_OK;
          end
        end
      end
      default: begin
        s_next.st = MPRT_ST_IDLE;
      end
    endcase
    // Abort wins over anything else once a channel exists
    if (cmd.valid && cmd.op == MPRT_OP_ABORT && s_reg.st != MPRT_ST_IDLE) begin
      s_next.st         = MPRT_ST_IDLE;
      s_next.req        = '0;
      s_next.confirmed  = '0;
      s_next.resp.valid = 1'b1;
      s_next.resp.code  = MPRT_RSP_OK;
    end else if (cmd.valid && (s_reg.st == MPRT_ST_CHECK || s_reg.st == MPRT_ST_SEND ||
                               s_reg.st == MPRT_ST_FIN)) begin
      s_next.resp.valid = 1'b1;
      s_next.resp.code  = MPRT_RSP_ERR;
    end
    // Registered copy of the open state so the pin comes straight from a flop
    s_next.chan_open = s_next.st != MPRT_ST_IDLE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Assembly store has no reset; only confirmed slots are ever sent
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      store[wr_addr] <= rx_byte.data;
    end
  end

  assign resp            = s_reg.resp;
  assign req             = s_reg.req;
  assign req_reply_count = s_reg.reply;
  assign channel_open    = s_reg.chan_open;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_abort_cmd;
    cmd.valid && cmd.op == MPRT_OP_ABORT && s_reg.st != MPRT_ST_IDLE;
  endsequence

  // A command in the finish cycle takes the single answer slot, so both checks leave it out
  sequence s_fin_good;
    s_reg.st == MPRT_ST_FIN && !s_reg.bad && 15'(s_reg.cnt) == expect_len &&
    (!s_reg.chk_en || sum == s_reg.chk_byte) && !cmd.valid;
  endsequence

  a_req_only_send : assert property (req.valid |-> s_reg.st == MPRT_ST_SEND)
    else $error("request data outside issue phase");
  a_req_after_check : assert property (
    $rose(req.valid) |-> $past(s_reg.st, 2) == MPRT_ST_CHECK)
    else $error("request started without close check");
  a_abort_ends : assert property (s_abort_cmd |=> s_reg.st == MPRT_ST_IDLE &&
    !req.valid && resp.valid && resp.code == MPRT_RSP_OK)
    else $error("abort did not drop the channel");
  a_idle_reject : assert property (
    cmd.valid && s_reg.st == MPRT_ST_IDLE && cmd.op != MPRT_OP_OPEN
    |=> resp.valid && resp.code == MPRT_RSP_ERR && s_reg.st == MPRT_ST_IDLE)
    else $error("command without channel not rejected");
  a_fail_answer : assert property (
    s_reg.st == MPRT_ST_FIN && !cmd.valid && (s_reg.bad || 15'(s_reg.cnt) != expect_len ||
    (s_reg.chk_en && sum != s_reg.chk_byte))
    |=> resp.valid && resp.code == MPRT_RSP_FAIL && !s_reg.confirmed[s_reg.seq])
    else $error("bad sub-packet not answered with failure");
  a_good_accept : assert property (s_fin_good |=> resp.valid &&
    resp.code == MPRT_RSP_OK && s_reg.confirmed[s_reg.seq])
    else $error("good sub-packet not confirmed");
  a_sub_limit : assert property (wr_en |-> s_reg.cnt < MPRT_SW'(MPRT_MAX_SUB))
    else $error("sub-packet byte stored past limit");
  a_total_limit : assert property (wr_en |-> wr_addr < s_reg.total)
    else $error("byte stored past total length");
  a_req_hold : assert property (req.valid && !req_ready && !cmd.valid
    |=> req.valid && $stable(req.data) && $stable(req.last))
    else $error("request byte changed while stalled");
  a_miss_back : assert property (
    s_reg.st == MPRT_ST_CHECK && s_reg.off < 15'(s_reg.total) &&
    !s_reg.confirmed[s_reg.idx] && !cmd.valid
    |=> resp.valid && resp.code == MPRT_RSP_MISS && s_reg.st == MPRT_ST_OPEN)
    else $error("missing sub-packet not reported");

endmodule
`default_nettype wire

// ==== bench/mprt_host_model.sv ====
// Host application model that opens, feeds, closes and aborts transfer channels
`timescale 1ns/100ps
`default_nettype none
module mprt_host_model
  import mprt_pkg::*;
(
  input  wire logic core_clk,
  output mprt_cmd_t  cmd,
  output mprt_byte_t rx_byte
);
  initial begin
    cmd     = '0;
    rx_byte = '0;
  end

  // One command pulse; fields are scrambled afterwards so stale values never look valid
  // The word is built aside and driven in one assignment per edge
  task automatic command(input mprt_op_t op, input int total, input int size,
                         input logic chk, input int rc);
    mprt_cmd_t c;
    c                 = cmd;
    c.valid           = 1'b1;
    c.op              = op;
    c.total_length    = total[MPRT_AW-1:0];
    c.sub_packet_size = size[MPRT_SW-1:0];
    c.checksum_enable = chk;
    c.reply_count     = rc[7:0];
    @(negedge core_clk);
    cmd = c;
    c       = mprt_cmd_t'(~c);
    c.valid = 1'b0;
    @(negedge core_clk);
    cmd = c;
  endtask

  // Data command, then its bytes on the following cycles; bad spoils the check byte
  task automatic packet(input int seq, input logic [7:0] d[$], input logic chk,
                        input logic bad);
    logic [7:0] sum;
    mprt_cmd_t  c;
    mprt_byte_t b;
    sum = 8'h00;
    foreach (d[i]) sum += d[i]; // Sequence byte left out, sum wraps at 8 bits
    if (chk) d.push_back(bad ? ~sum : sum);
    c       = cmd;
    c.valid = 1'b1;
    c.op    = MPRT_OP_DATA;
    c.seq   = seq[7:0];
    b       = rx_byte;
    @(negedge core_clk);
    cmd = c;
    c.valid = 1'b0;
    foreach (d[i]) begin
      b.valid = 1'b1;
      b.data  = d[i];
      b.last  = (i == d.size() - 1);
      @(negedge core_clk);
      if (i == 0) cmd = c;
      rx_byte = b;
    end
    // Released line shows the inverse so a stuck capture cannot match
    b.valid = 1'b0;
    b.data  = ~b.data;
    b.last  = 1'b0;
    @(negedge core_clk);
    rx_byte = b;
  endtask
endmodule
`default_nettype wire

// ==== bench/test_mprt_receiver.sv ====
// Self-checking bench for the multi-packet request receiver
`timescale 1ns/100ps
`default_nettype none
module test_mprt_receiver
  import mprt_pkg::*;
;
  logic       core_clk  = 1'b0;
  logic       rst       = 1'b1;
  logic       req_ready = 1'b0;
  logic [3:0] stall     = 4'h0;
  mprt_cmd_t  cmd;
  mprt_byte_t rx_byte;
  mprt_resp_t resp;
  mprt_req_t  req;
  logic [7:0] req_reply_count;
  logic       channel_open;
  mprt_rsp_t  got_code;
  logic [7:0] rx_q[$];
  int         last_pos;
  int         n_resp;
  int         n_fail;
  int         checks;

  mprt_receiver mprt_receiver_i (.core_clk(core_clk), .rst(rst), .cmd(cmd), .rx_byte(rx_byte),
    .req_ready(req_ready), .resp(resp), .req(req), .req_reply_count(req_reply_count),
    .channel_open(channel_open));
  mprt_host_model mprt_host_model_i (.core_clk(core_clk), .cmd(cmd), .rx_byte(rx_byte));

  always #5 core_clk = ~core_clk;

  // Vehicle side stalls one cycle in four so the request stream must hold its bytes
  always @(negedge core_clk) begin
    stall     <= stall + 4'h1;
    req_ready <= (stall[1:0] != 2'b11);
  end

  // Answers and accepted request bytes are captured where they are sampled
  always @(posedge core_clk) begin
    if (resp.valid === 1'b1) begin
      got_code = resp.code;
      n_resp++;
    end
    if (req.valid === 1'b1 && req_ready) begin
      rx_q.push_back(req.data);
      if (req.last === 1'b1) last_pos = rx_q.size();
    end
  end

  task automatic bad(input string msg);
    n_fail++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic cmp_rsp(input mprt_rsp_t got, input mprt_rsp_t exp);
    checks++;
    if (got !== exp) bad("wrong answer code");
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) bad("wrong byte value");
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) bad("wrong flag level");
  endtask
  task automatic cmp_n(input int got, input int exp);
    checks++;
    if (got != exp) bad("wrong byte count");
  endtask

  // Bounded wait for the next answer pulse, then judge its code
  task automatic expect_rsp(input mprt_rsp_t exp);
    int n0;
    n0 = n_resp;
    for (int k = 0; k < 300 && n_resp == n0; k++) @(negedge core_clk);
    if (n_resp == n0) bad("no answer");
    cmp_rsp(got_code, exp);
  endtask

  task automatic t_idle();
    mprt_op_t ops[3] = '{MPRT_OP_DATA, MPRT_OP_CLOSE, MPRT_OP_ABORT};
    cmp1(channel_open, 1'b0);
    foreach (ops[i]) begin
      mprt_host_model_i.command(ops[i], 4, 2, 1'b1, 1);
      expect_rsp(MPRT_RSP_ERR);
      cmp1(channel_open, 1'b0);
    end
  endtask

  task automatic t_bad_open();
    int tot[5] = '{0, 4129, 8, 8, 4128};
    int siz[5] = '{2, 2, 0, 91, 16};
    foreach (tot[i]) begin
      mprt_host_model_i.command(MPRT_OP_OPEN, tot[i], siz[i], 1'b1, 1);
      expect_rsp(MPRT_RSP_ERR);
      cmp1(channel_open, 1'b0);
    end
  endtask

  task automatic t_limits();
    mprt_host_model_i.command(MPRT_OP_OPEN, 4128, 90, 1'b1, 1);
    expect_rsp(MPRT_RSP_OK);
    cmp1(channel_open, 1'b1);
    mprt_host_model_i.command(MPRT_OP_OPEN, 8, 2, 1'b1, 1);
    expect_rsp(MPRT_RSP_ERR);
    mprt_host_model_i.command(MPRT_OP_ABORT, 0, 0, 1'b0, 0);
    expect_rsp(MPRT_RSP_OK);
    cmp1(channel_open, 1'b0);
  endtask

  task automatic t_transfer();
    logic [7:0] exp[5] = '{8'hff, 8'h02, 8'h10, 8'h20, 8'h33};
    rx_q.delete();
    last_pos = 0;
    mprt_host_model_i.command(MPRT_OP_OPEN, 5, 2, 1'b1, 0);
    expect_rsp(MPRT_RSP_OK);
    mprt_host_model_i.packet(0, '{8'hff, 8'h02}, 1'b1, 1'b0);
    expect_rsp(MPRT_RSP_OK);
    mprt_host_model_i.packet(1, '{8'h10, 8'h20}, 1'b1, 1'b1);
    expect_rsp(MPRT_RSP_FAIL);
    mprt_host_model_i.packet(2, '{8'h33}, 1'b1, 1'b0);
    expect_rsp(MPRT_RSP_OK);
    mprt_host_model_i.command(MPRT_OP_CLOSE, 0, 0, 1'b0, 7);
    expect_rsp(MPRT_RSP_MISS);
    cmp_n(rx_q.size(), 0);
    cmp1(channel_open, 1'b1);
    // Two good resends of the failed slot; the later one simply replaces the earlier
    repeat (2) begin
      mprt_host_model_i.packet(1, '{8'h10, 8'h20}, 1'b1, 1'b0);
      expect_rsp(MPRT_RSP_OK);
    end
    cmp_n(rx_q.size(), 0);
    mprt_host_model_i.command(MPRT_OP_CLOSE, 0, 0, 1'b0, 3);
    expect_rsp(MPRT_RSP_OK);
    cmp_n(rx_q.size(), 5);
    foreach (exp[i]) cmp8(rx_q[i], exp[i]);
    cmp_n(last_pos, 5);
    cmp8(req_reply_count, 8'h03);
    cmp1(channel_open, 1'b0);
  endtask

  task automatic t_abort();
    rx_q.delete();
    last_pos = 0;
    mprt_host_model_i.command(MPRT_OP_OPEN, 4, 2, 1'b0, 0);
    expect_rsp(MPRT_RSP_OK);
    mprt_host_model_i.packet(0, '{8'h01, 8'h02}, 1'b0, 1'b0);
    expect_rsp(MPRT_RSP_OK);
    // A short sub-packet fails on length alone and must be sent again in full
    mprt_host_model_i.packet(1, '{8'h03}, 1'b0, 1'b0);
    expect_rsp(MPRT_RSP_FAIL);
    mprt_host_model_i.packet(1, '{8'h03, 8'h04}, 1'b0, 1'b0);
    expect_rsp(MPRT_RSP_OK);
    mprt_host_model_i.command(MPRT_OP_CLOSE, 0, 0, 1'b0, 1);
    for (int k = 0; k < 100 && rx_q.size() == 0; k++) @(negedge core_clk);
    // Abort lands while the request is still streaming out
    mprt_host_model_i.command(MPRT_OP_ABORT, 0, 0, 1'b0, 0);
    expect_rsp(MPRT_RSP_OK);
    cmp1(channel_open, 1'b0);
    repeat (20) @(negedge core_clk);
    cmp8(rx_q[0], 8'h01);
    cmp1(rx_q.size() < 4, 1'b1);
    cmp_n(last_pos, 0);
    mprt_host_model_i.command(MPRT_OP_CLOSE, 0, 0, 1'b0, 1);
    expect_rsp(MPRT_RSP_ERR);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_idle();
    t_bad_open();
    t_limits();
    t_transfer();
    t_abort();
    tally_and_finish();
  end

  // Watchdog at 10000 cycles, well past the few hundred cycles the scenarios need
  initial begin
    #100us;
    bad("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire
